/* bench/du_host_model.sv */
`timescale 1ns/100ps
// host processor on the multiplexed address/data strobe bus
module du_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dev_bus_i,
  input  wire logic       dev_oe_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            lla_n_o,
  output logic      [7:0] bus_o
);
  logic       drv_en;
  logic [7:0] drv_v;

  // ---------------------------------------------------------------
  // wire level of the shared bus
  // ---------------------------------------------------------------
  // no pull on these lines: a released bus shows the inverse of the
  // last host byte, so a stale value can never pass for read data
  assign bus_o = dev_oe_i ? dev_bus_i : (drv_en ? drv_v : ~drv_v);

  // idle pins at time zero
  initial begin
    cs_n_o  = 1'b1;
    rd_n_o  = 1'b1;
    wr_n_o  = 1'b1;
    lla_n_o = 1'b1;
    drv_en  = 1'b0;
    drv_v   = 8'h00;
  end

  // one whole cycle: address phase, data phase, strobe, release
  task automatic access(input  logic       sel,
                        input  logic       wr,
                        input  logic [7:0] adr,
                        input  logic [7:0] dat,
                        output logic [7:0] rd_v,
                        output logic       got);
    int n;
    rd_v = 8'h00;
    got  = 1'b0;
    @(posedge clk_i);
    cs_n_o  <= ~sel;
    lla_n_o <= 1'b0;
    drv_en  <= 1'b1;
    drv_v   <= adr;
    repeat (3) @(posedge clk_i);
    lla_n_o <= 1'b1;
    drv_en  <= wr;
    drv_v   <= dat;
    repeat (2) @(posedge clk_i);
    rd_n_o  <= wr;
    wr_n_o  <= ~wr;
    // strobe held six cycles; the answer is taken once it is settled
    for (n = 0; n < 6; n++) begin
      @(negedge clk_i);
      if (!wr && !got && dev_oe_i === 1'b1) begin
        got  = 1'b1;
        rd_v = bus_o;
      end
    end
    @(posedge clk_i);
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    // select and data stay put past the rising strobe, then release
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    drv_en <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

/* bench/test_du_top.sv */
`timescale 1ns/100ps
module test_du_top
  import du_pkg::*;
();
  localparam logic [5:0] PATS [3] = '{6'h2A, 6'h15, 6'h19};
  logic       clk;
  logic       rst;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       lla_n;
  logic [7:0] bus_w;
  logic [7:0] dev_bus;
  logic       dev_oe;
  logic [6:0] pins;
  logic [5:0] modem;
  logic [1:0] irq_req;
  logic [7:0] rv;
  logic       got;
  int         failures;
  int         checks_done;

  // ---------------------------------------------------------------
  // clock, host and device
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  du_host_model host_u (
    .clk_i(clk), .dev_bus_i(dev_bus), .dev_oe_i(dev_oe), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .lla_n_o(lla_n), .bus_o(bus_w)
  );

  // pins: 0/1 terminal ready a/b, 2/3 irq a value/oe, 4/5 irq b, 6 bus oe
  du_top dut_u (
    .CLK_I(clk), .RST_I(rst), .CHIP_SELECT_N_I(cs_n),
    .READ_STROBE_N_I(rd_n), .WRITE_STROBE_N_I(wr_n),
    .LATCH_LOWER_ADDRESS_N_I(lla_n), .MUXED_BUS_I(bus_w),
    .MUXED_BUS_O(dev_bus), .MUXED_BUS_OE_O(dev_oe),
    .CLEAR_TO_SEND_IN_A_N_I(modem[0]), .CLEAR_TO_SEND_IN_B_N_I(modem[1]),
    .SET_READY_IN_A_N_I(modem[2]), .SET_READY_IN_B_N_I(modem[3]),
    .CARRIER_DETECT_IN_A_N_I(modem[4]), .CARRIER_DETECT_IN_B_N_I(modem[5]),
    .IRQ_REQ_A_I(irq_req[0]), .IRQ_REQ_B_I(irq_req[1]),
    .TERMINAL_READY_OUT_A_N_O(pins[0]), .TERMINAL_READY_OUT_B_N_O(pins[1]),
    .IRQ_OUT_A_O(pins[2]), .IRQ_OUT_A_OE_O(pins[3]),
    .IRQ_OUT_B_O(pins[4]), .IRQ_OUT_B_OE_O(pins[5])
  );
  assign pins[6] = dev_oe;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // channel goes on address bit six, index on bits 2:0
  task automatic acc(input logic sel, input logic wr, input logic ch,
                     input logic [2:0] idx, input logic [7:0] dat);
    host_u.access(sel, wr, {1'b0, ch, 3'h0, idx}, dat, rv, got);
  endtask

  // pin changes need a few cycles to cross the input synchronisers
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask

  function automatic logic [7:0] msr_exp(input int ch);
    return {~modem[4+ch], 1'b0, ~modem[2+ch], ~modem[ch], 4'h0};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    failures    = 0;
    checks_done = 0;
    rst         = 1'b1;
    modem       = 6'h3F;
    irq_req     = 2'b01;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle();
    check({1'b0, pins}, 8'h03);
    $display("test reset done");
    // enable channel a, then b; the other channel must not move
    acc(1'b1, 1'b1, 1'b0, DU_MCR_IDX, 8'h89);
    settle();
    check({1'b0, pins}, 8'h0E);
    acc(1'b1, 1'b1, 1'b1, DU_MCR_IDX, 8'h19);
    settle();
    check({1'b0, pins}, 8'h2C);
    @(posedge clk);
    irq_req <= 2'b11;
    settle();
    check({1'b0, pins}, 8'h3C);
    acc(1'b1, 1'b0, 1'b0, DU_MCR_IDX, 8'h00);
    check(rv, 8'h89);
    acc(1'b1, 1'b0, 1'b1, DU_MCR_IDX, 8'h00);
    check(rv, 8'h19);
    $display("test control done");
    // deselected cycles: no write lands, no read is answered
    acc(1'b0, 1'b1, 1'b0, DU_MCR_IDX, 8'h00);
    acc(1'b0, 1'b0, 1'b0, DU_MCR_IDX, 8'h00);
    check({7'h00, got}, 8'h00);
    acc(1'b1, 1'b0, 1'b0, DU_MCR_IDX, 8'h00);
    check(rv, 8'h89);
    $display("test select done");
    // modem input patterns seen per channel
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      modem <= PATS[k];
      settle();
      for (int c = 0; c < 2; c++) begin
        acc(1'b1, 1'b0, c[0], DU_MSR_IDX, 8'h00);
        check(rv, msr_exp(c));
      end
    end
    $display("test status done");
    // clear channel a, then a reset in mid-run
    acc(1'b1, 1'b1, 1'b0, DU_MCR_IDX, 8'h00);
    settle();
    check({1'b0, pins}, 8'h31);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    check({1'b0, pins}, 8'h03);
    acc(1'b1, 1'b0, 1'b1, DU_MCR_IDX, 8'h00);
    check(rv, 8'h00);
    $display("test reset again done");
    report_and_stop();
  end

  // a hang is cut short well beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule

/* include/du_chan_if.sv */
`timescale 1ns/100ps
// register access path from the host sequencer to one channel
interface du_chan_if;
  logic       wr_stb;   // one-cycle write pulse
  logic [2:0] reg_idx;  // register index
  logic [7:0] wdata;    // write byte
  logic [7:0] rdata;    // read byte of the indexed register

  modport host (output wr_stb, output reg_idx, output wdata,
                input rdata);
  modport chan (input wr_stb, input reg_idx, input wdata,
                output rdata);
endinterface

/* include/du_pkg.sv */
package du_pkg;

  // ---------------------------------------------------------------
  // register indices inside a channel (low latched address bits)
  // ---------------------------------------------------------------
  localparam logic [2:0] DU_MCR_IDX    = 3'h4; // modem_control_reg
  localparam logic [2:0] DU_MSR_IDX    = 3'h6; // modem_status_reg
  localparam int         DU_IDX_LSB    = 0;
  localparam int         DU_IDX_MSB    = 2;
  localparam int         DU_CHAN_BIT   = 6;    // channel_select_addr_bit

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         DU_MCR_DTR    = 0;
  localparam int         DU_MCR_IRQEN  = 3;
  localparam int         DU_MSR_CTS    = 4;
  localparam int         DU_MSR_DSR    = 5;
  localparam int         DU_MSR_CD     = 7;
  localparam logic [7:0] DU_MCR_RST    = 8'h00;
  localparam logic [7:0] DU_MSR_RST    = 8'h00;
  localparam logic [7:0] DU_BYTE_ZERO  = 8'h00;
  localparam logic [7:0] DU_ADDR_RST   = 8'h00;

  // ---------------------------------------------------------------
  // host strobe sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DU_ST_IDLE  = 3'b001,
    DU_ST_READ  = 3'b010,
    DU_ST_WRITE = 3'b100
  } du_state_type;

endpackage

/* rtl/du_chan.sv */
`timescale 1ns/100ps
module du_chan
  import du_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  du_chan_if.chan   bus,
  input  wire logic cts_n_i,
  input  wire logic dsr_n_i,
  input  wire logic cd_n_i,
  input  wire logic irq_req_i,
  output logic      dtr_n_o,
  output logic      irq_o,
  output logic      irq_oe_o
);

  // ---------------------------------------------------------------
  // modem pin synchronisers and channel state
  // ---------------------------------------------------------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [7:0] mcr_q;
  logic [7:0] mcr_d;
  logic [7:0] msr_q;
  logic [7:0] msr_d;
  logic       dtr_n_q;
  logic       dtr_n_d;
  logic       irq_q;
  logic       irq_d;
  logic       irq_oe_q;
  logic       irq_oe_d;
  logic [1:0] rst_age_q;
  logic [1:0] rst_age_d;

  // next values; each channel keeps its own copy
  always_comb begin
    mcr_d = mcr_q;
    if (bus.wr_stb && bus.reg_idx == DU_MCR_IDX) begin
      mcr_d = bus.wdata;
    end
    // pins are active low, status reads one for an asserted pin
    msr_d = DU_BYTE_ZERO;
    msr_d[DU_MSR_CTS] = ~pin_s2_q[0];
    msr_d[DU_MSR_DSR] = ~pin_s2_q[1];
    msr_d[DU_MSR_CD]  = ~pin_s2_q[2];
    dtr_n_d  = ~mcr_q[DU_MCR_DTR];
    irq_oe_d = mcr_q[DU_MCR_IRQEN];
    // gate the value too so a released pin never carries a stale level
    irq_d    = irq_req_i & mcr_q[DU_MCR_IRQEN];
    // cycles since reset, saturating; status only tracks the pins once
    // both synchroniser stages and the status register have refilled
    rst_age_d = rst_age_q;
    if (rst_age_q != 2'h3) begin
      rst_age_d = rst_age_q + 2'h1;
    end
  end

  // registers; reset forces the terminal-ready pin high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      mcr_q    <= DU_MCR_RST;
      msr_q    <= DU_MSR_RST;
      dtr_n_q  <= 1'b1;
      irq_q    <= 1'b0;
      irq_oe_q <= 1'b0;
      rst_age_q <= 2'h0;
    end else begin
      pin_s1_q <= {cd_n_i, dsr_n_i, cts_n_i};
      pin_s2_q <= pin_s1_q;
      mcr_q    <= mcr_d;
      msr_q    <= msr_d;
      dtr_n_q  <= dtr_n_d;
      irq_q    <= irq_d;
      irq_oe_q <= irq_oe_d;
      rst_age_q <= rst_age_d;
    end
  end

  // read mux; unimplemented indices read as zero
  always_comb begin
    case (bus.reg_idx)
      DU_MCR_IDX: bus.rdata = mcr_q;
      DU_MSR_IDX: bus.rdata = msr_q;
      default:    bus.rdata = DU_BYTE_ZERO;
    endcase
  end

  assign dtr_n_o  = dtr_n_q;
  assign irq_o    = irq_q;
  assign irq_oe_o = irq_oe_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_mcr_write(logic b);
    bus.wr_stb && bus.reg_idx == DU_MCR_IDX && bus.wdata[DU_MCR_DTR] == b;
  endsequence

  chk_dtr_low_on_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_mcr_write(1'b1) |-> ##2 !dtr_n_o)
    else $error("terminal ready not low after control bit set");
  chk_dtr_high_on_clr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_mcr_write(1'b0) |-> ##2 dtr_n_o)
    else $error("terminal ready not high after control bit cleared");
  chk_dtr_after_reset: assert property (
    @(posedge clk_i) rst_i |=> dtr_n_o)
    else $error("terminal ready not high after reset");
  chk_cts_status_bit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rst_age_q == 2'h3 |-> msr_q[DU_MSR_CTS] == !$past(cts_n_i, 3))
    else $error("clear to send status wrong");
  chk_dsr_status_bit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rst_age_q == 2'h3 |-> msr_q[DU_MSR_DSR] == !$past(dsr_n_i, 3))
    else $error("set ready status wrong");
  chk_cd_status_bit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rst_age_q == 2'h3 |-> msr_q[DU_MSR_CD] == !$past(cd_n_i, 3))
    else $error("carrier detect status wrong");
  chk_irq_drive_on: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mcr_q[DU_MCR_IRQEN] |=> irq_oe_o && irq_o == $past(irq_req_i))
    else $error("interrupt pin not driven while enabled");
  chk_irq_float_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !mcr_q[DU_MCR_IRQEN] |=> !irq_oe_o && !irq_o)
    else $error("interrupt pin driven while disabled");
  chk_mcr_hold_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !bus.wr_stb |=> $stable(mcr_q))
    else $error("control register changed without own write");

endmodule

/* rtl/du_top.sv */
`timescale 1ns/100ps
// Operation
// - register data moves only while chip select is low, and only for the addressed channel.
// - latched address bit six zero picks channel A, one picks channel B.
// - a low clear-to-send pin means ready for transmit data and reads as status bit 4.
// - a low set-ready pin means the modem is powered and ready and reads as status bit 5.
// - a low carrier-detect pin means a carrier was found on that channel.
// - writing one to control bit 0 drives the terminal-ready pin low.
// - writing zero to control bit 0, or any reset, drives the terminal-ready pin high.
// - control bit 3 at one makes the interrupt pin actively driven.
// - control bit 3 at zero leaves the interrupt pin floating.
// - a falling read strobe starts a read that puts the addressed byte on the bus.
// - a falling write strobe starts a write and the rising edge loads the bus byte.
// - while latch-lower-address is low the bus byte is caught as the address.
// - bus line zero is the least significant bit for address and data alike.
module du_top
  import du_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CHIP_SELECT_N_I,
  input  wire logic       READ_STROBE_N_I,
  input  wire logic       WRITE_STROBE_N_I,
  input  wire logic       LATCH_LOWER_ADDRESS_N_I,
  input  wire logic [7:0] MUXED_BUS_I,
  output logic      [7:0] MUXED_BUS_O,
  output logic            MUXED_BUS_OE_O,
  input  wire logic       CLEAR_TO_SEND_IN_A_N_I,
  input  wire logic       CLEAR_TO_SEND_IN_B_N_I,
  input  wire logic       SET_READY_IN_A_N_I,
  input  wire logic       SET_READY_IN_B_N_I,
  input  wire logic       CARRIER_DETECT_IN_A_N_I,
  input  wire logic       CARRIER_DETECT_IN_B_N_I,
  input  wire logic       IRQ_REQ_A_I,
  input  wire logic       IRQ_REQ_B_I,
  output logic            TERMINAL_READY_OUT_A_N_O,
  output logic            TERMINAL_READY_OUT_B_N_O,
  output logic            IRQ_OUT_A_O,
  output logic            IRQ_OUT_A_OE_O,
  output logic            IRQ_OUT_B_O,
  output logic            IRQ_OUT_B_OE_O
);

  // ---------------------------------------------------------------
  // host pin synchronisers
  // ---------------------------------------------------------------
  // bus and strobes share the same two-stage delay, so the byte
  // sampled beside a strobe edge is the one the host held there
  logic [11:0] pin_s1_q;
  logic [11:0] pin_s2_q;
  logic [1:0]  strb_p_q;   // previous synchronised write/read strobes
  logic [7:0]  bus_s;
  logic        cs_n_s;
  logic        rd_n_s;
  logic        wr_n_s;
  logic        lla_n_s;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pin_s1_q <= 12'hF00;
      pin_s2_q <= 12'hF00;
      strb_p_q <= 2'h3;
    end else begin
      pin_s1_q <= {LATCH_LOWER_ADDRESS_N_I, WRITE_STROBE_N_I,
                   READ_STROBE_N_I, CHIP_SELECT_N_I, MUXED_BUS_I};
      pin_s2_q <= pin_s1_q;
      strb_p_q <= pin_s2_q[10:9];
    end
  end

  assign bus_s   = pin_s2_q[7:0];      // line zero is bit zero
  assign cs_n_s  = pin_s2_q[8];
  assign rd_n_s  = pin_s2_q[9];
  assign wr_n_s  = pin_s2_q[10];
  assign lla_n_s = pin_s2_q[11];

  logic rd_fall;
  logic wr_fall;
  logic wr_rise;
  assign rd_fall = strb_p_q[0] & ~rd_n_s;
  assign wr_fall = strb_p_q[1] & ~wr_n_s;
  assign wr_rise = ~strb_p_q[1] & wr_n_s;

  // ---------------------------------------------------------------
  // address latch and strobe sequencer
  // ---------------------------------------------------------------
  du_state_type st_q;
  du_state_type st_d;
  logic [7:0]   addr_q;
  logic [7:0]   addr_d;
  logic [7:0]   rdo_q;
  logic [7:0]   rdo_d;
  logic         oe_q;
  logic         oe_d;
  logic         wr_a_q;
  logic         wr_a_d;
  logic         wr_b_q;
  logic         wr_b_d;
  logic [7:0]   wdat_q;
  logic [7:0]   wdat_d;
  logic         chan_b;
  logic [7:0]   rd_a;
  logic [7:0]   rd_b;

  assign chan_b = addr_q[DU_CHAN_BIT];

  // next values of the host side
  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    rdo_d  = rdo_q;
    oe_d   = 1'b0;
    wr_a_d = 1'b0;
    wr_b_d = 1'b0;
    wdat_d = wdat_q;
    if (!lla_n_s) begin
      addr_d = bus_s;
    end
    case (st_q)
      DU_ST_IDLE: begin
        if (!cs_n_s && rd_fall) begin
          st_d  = DU_ST_READ;
          rdo_d = chan_b ? rd_b : rd_a;
          oe_d  = 1'b1;
        end else if (!cs_n_s && wr_fall) begin
          st_d = DU_ST_WRITE;
        end
      end
      DU_ST_READ: begin
        // drive only while select and strobe stay low
        if (cs_n_s || rd_n_s) begin
          st_d = DU_ST_IDLE;
        end else begin
          oe_d = 1'b1;
        end
      end
      DU_ST_WRITE: begin
        // a write whose select lifted early is dropped
        if (cs_n_s) begin
          st_d = DU_ST_IDLE;
        end else if (wr_rise) begin
          st_d   = DU_ST_IDLE;
          wdat_d = bus_s;
          wr_a_d = ~chan_b;
          wr_b_d = chan_b;
        end
      end
      default: begin
        st_d = DU_ST_IDLE;
      end
    endcase
  end

  // host side registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_q   <= DU_ST_IDLE;
      addr_q <= DU_ADDR_RST;
      rdo_q  <= DU_BYTE_ZERO;
      oe_q   <= 1'b0;
      wr_a_q <= 1'b0;
      wr_b_q <= 1'b0;
      wdat_q <= DU_BYTE_ZERO;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      rdo_q  <= rdo_d;
      oe_q   <= oe_d;
      wr_a_q <= wr_a_d;
      wr_b_q <= wr_b_d;
      wdat_q <= wdat_d;
    end
  end

  assign MUXED_BUS_O    = rdo_q;
  assign MUXED_BUS_OE_O = oe_q;

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  du_chan_if ch_a_if ();
  du_chan_if ch_b_if ();

  assign ch_a_if.wr_stb  = wr_a_q;
  assign ch_a_if.reg_idx = addr_q[DU_IDX_MSB:DU_IDX_LSB];
  assign ch_a_if.wdata   = wdat_q;
  assign rd_a            = ch_a_if.rdata;
  assign ch_b_if.wr_stb  = wr_b_q;
  assign ch_b_if.reg_idx = addr_q[DU_IDX_MSB:DU_IDX_LSB];
  assign ch_b_if.wdata   = wdat_q;
  assign rd_b            = ch_b_if.rdata;

  du_chan u_chan_a (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .bus       (ch_a_if),
    .cts_n_i   (CLEAR_TO_SEND_IN_A_N_I),
    .dsr_n_i   (SET_READY_IN_A_N_I),
    .cd_n_i    (CARRIER_DETECT_IN_A_N_I),
    .irq_req_i (IRQ_REQ_A_I),
    .dtr_n_o   (TERMINAL_READY_OUT_A_N_O),
    .irq_o     (IRQ_OUT_A_O),
    .irq_oe_o  (IRQ_OUT_A_OE_O)
  );

  du_chan u_chan_b (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .bus       (ch_b_if),
    .cts_n_i   (CLEAR_TO_SEND_IN_B_N_I),
    .dsr_n_i   (SET_READY_IN_B_N_I),
    .cd_n_i    (CARRIER_DETECT_IN_B_N_I),
    .irq_req_i (IRQ_REQ_B_I),
    .dtr_n_o   (TERMINAL_READY_OUT_B_N_O),
    .irq_o     (IRQ_OUT_B_O),
    .irq_oe_o  (IRQ_OUT_B_OE_O)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_write_phase;
    st_q == DU_ST_WRITE && !cs_n_s && wr_rise;
  endsequence

  chk_write_needs_cs: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (wr_a_q || wr_b_q) |-> $past(!cs_n_s) && $past(st_q == DU_ST_WRITE))
    else $error("write pulse without chip select");
  chk_drive_needs_cs: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    MUXED_BUS_OE_O |-> $past(!cs_n_s && !rd_n_s))
    else $error("bus driven without select and read strobe");
  chk_chan_route_bit: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    s_write_phase |=> (wr_b_q == $past(chan_b)) && (wr_a_q != wr_b_q))
    else $error("write routed to wrong channel");
  chk_read_drives_bus: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (st_q == DU_ST_IDLE && !cs_n_s && rd_fall) |=>
      MUXED_BUS_OE_O && MUXED_BUS_O == $past(chan_b ? rd_b : rd_a))
    else $error("read start did not drive the addressed byte");
  chk_write_loads_byte: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    s_write_phase |=> (wr_a_q || wr_b_q) && wdat_q == $past(bus_s))
    else $error("write strobe rise did not load the bus byte");
  chk_addr_latch_low: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !lla_n_s |=> addr_q == $past(bus_s))
    else $error("address not captured during address phase");
  chk_addr_hold_high: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    lla_n_s |=> $stable(addr_q))
    else $error("address changed during data phase");

endmodule
